// ===== sssd_pkg.sv
// package: constants and types for the seven-segment scan driver
// ----------------------------------------------------------------
// Behaviour
// - any of the 16 hex font patterns 0 to F can be shown on any digit.
// - seven shared segment lines A to G plus a decimal point serve all digits.
// - digit enables and segment lines are active low: 0 enables or lights.
// - the four digit enables are asserted one at a time in an endless cycle.
// - all four digits are revisited once every 1 to 16 ms.
// - the refresh rate stays well above the 45 Hz flicker point.
// - a digit's pattern is on the segment lines exactly while it is enabled.
// - enable 0 is the rightmost digit; B,C shows one and A,B,C shows seven.
// ----------------------------------------------------------------
package sssd_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned DIGIT_US = 1000;
  localparam int unsigned DIGIT_CYCLES = CLK_HZ / 1_000_000 * DIGIT_US;
  localparam int unsigned NUM_DIGITS = 4;
  localparam logic [3:0] ENABLES_OFF = 4'hf;
  localparam logic [7:0] CATHODES_OFF = 8'hff;

  // segment lines, active low, bit 0 = segment a ... bit 6 = g, bit 7 = dp
  typedef struct packed {
    logic decimal_point_n;
    logic [6:0] segment_cathode_n;
  } sssd_seg_t;

  typedef struct packed {
    logic dp;
    logic [3:0] value;
  } sssd_digit_t;
endpackage

// ===== sssd_scan_driver.sv
// module: four-digit common-anode seven-segment scan driver
`timescale 1ns/10ps
`default_nettype none
module sssd_scan_driver
  import sssd_pkg::*;
#(
  parameter int unsigned DIGIT_TICKS = DIGIT_CYCLES
) (
  // clock and reset
  input wire logic mclk_in,
  input wire logic rstn_in,
  // display values, digit 0 rightmost
  input wire sssd_digit_t digits_in [NUM_DIGITS],
  // display pins
  output logic [3:0] digit_enable_n_out,
  output sssd_seg_t segments_out
);
  // ----------------------------------------------------------------
  // divider and digit index
  // ----------------------------------------------------------------
  logic [31:0] div_q, div_d;
  logic [1:0] idx_q, idx_d;
  logic tick;

  always_comb begin
    tick = (div_q == 32'(DIGIT_TICKS - 1));
    div_d = tick ? 32'h0 : div_q + 32'h1;
    idx_d = tick ? idx_q + 2'h1 : idx_q;
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      // preload to the last count of the last digit so that the first edge
      // out of reset enters digit 0 with a full dwell, not one cycle short
      div_q <= 32'(DIGIT_TICKS - 1);
      idx_q <= 2'(NUM_DIGITS - 1);
    end else begin
      div_q <= div_d;
      idx_q <= idx_d;
    end
  end

  // ----------------------------------------------------------------
  // decode and output registers
  // ----------------------------------------------------------------
  // enable and pattern register on the same edge so no ghosting occurs
  logic [3:0] en_q, en_d;
  sssd_seg_t seg_q, seg_d;
  sssd_digit_t cur;
  logic [6:0] lit;

  always_comb begin
    cur = digits_in[idx_d];
    // lit bits active high: a..g = bit 0..6
    unique case (cur.value)
      4'h0: lit = 7'h3f;
      4'h1: lit = 7'h06;
      4'h2: lit = 7'h5b;
      4'h3: lit = 7'h4f;
      4'h4: lit = 7'h66;
      4'h5: lit = 7'h6d;
      4'h6: lit = 7'h7d;
      4'h7: lit = 7'h07;
      4'h8: lit = 7'h7f;
      4'h9: lit = 7'h6f;
      4'ha: lit = 7'h77;
      4'hb: lit = 7'h7c;
      4'hc: lit = 7'h39;
      4'hd: lit = 7'h5e;
      4'he: lit = 7'h79;
      4'hf: lit = 7'h71;
    endcase
    seg_d.segment_cathode_n = ~lit;
    seg_d.decimal_point_n = ~cur.dp;
    en_d = ~(4'h1 << idx_d);
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      en_q <= ENABLES_OFF;
      seg_q <= CATHODES_OFF;
    end else begin
      en_q <= en_d;
      seg_q <= seg_d;
    end
  end

  assign digit_enable_n_out = en_q;
  assign segments_out = seg_q;

  // ----------------------------------------------------------------
  // check helpers
  // ----------------------------------------------------------------
  // dwell and frame lengths are counted here rather than by repetitions,
  // which would have to unroll DIGIT_TICKS deep in the tools
  logic en_moved;
  logic frame_start;
  logic [31:0] dwell_q, dwell_d;
  logic [31:0] frame_q, frame_d;

  always_comb begin
    en_moved = (en_d != en_q);
    frame_start = en_moved && (en_d == 4'he);
    dwell_d = en_moved ? 32'h1 : dwell_q + 32'h1;
    frame_d = frame_start ? 32'h1 : frame_q + 32'h1;
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      dwell_q <= 32'h0;
      frame_q <= 32'h0;
    end else begin
      dwell_q <= dwell_d;
      frame_q <= frame_d;
    end
  end

  // ----------------------------------------------------------------
  // checks: scan order and timing
  // ----------------------------------------------------------------
  // the move out of the blank reset state is not a dwell and is skipped
  one_hot_en_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> $onehot(~en_q))
    else $error("enable not one-hot");

  advance_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    tick |=> idx_q == 2'($past(idx_q) + 2'h1))
    else $error("bad advance");

  advance_rot_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    tick && $past(rstn_in) |=> en_q == {$past(en_q[2:0]), $past(en_q[3])})
    else $error("digit did not rotate");

  hold_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !tick && $past(rstn_in) |=> $stable(en_q))
    else $error("early change");

  refresh_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    div_q < 32'(DIGIT_TICKS))
    else $error("divider overrun");

  idx_enable_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> en_q == ~(4'h1 << idx_q))
    else $error("enable does not match index");

  dwell_length_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    en_moved && en_q != ENABLES_OFF |-> dwell_q == 32'(DIGIT_TICKS))
    else $error("digit dwell wrong");

  frame_length_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    frame_start && en_q != ENABLES_OFF
    |-> frame_q == 32'(NUM_DIGITS * DIGIT_TICKS))
    else $error("refresh period wrong");

  div_wrap_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    tick |=> div_q == 32'h0)
    else $error("divider did not wrap");

  div_count_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    !tick |=> div_q == 32'($past(div_q) + 32'h1))
    else $error("divider skipped a count");

  // ----------------------------------------------------------------
  // checks: reset
  // ----------------------------------------------------------------
  reset_blank_a: assert property (
    @(posedge mclk_in)
    !rstn_in |=> en_q == ENABLES_OFF)
    else $error("reset not blank");

  reset_segments_a: assert property (
    @(posedge mclk_in)
    !rstn_in |=> seg_q == CATHODES_OFF)
    else $error("segments lit in reset");

  first_digit_a: assert property (
    @(posedge mclk_in)
    !rstn_in ##1 rstn_in |=> en_q == 4'he)
    else $error("scan did not start at digit 0");

  // ----------------------------------------------------------------
  // checks: segment patterns
  // ----------------------------------------------------------------
  pattern_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) && digits_in[idx_d].value == 4'h1 && !digits_in[idx_d].dp
    |=> seg_q == 8'hf9)
    else $error("one pattern wrong");

  dp_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) |-> seg_q.decimal_point_n == ~$past(cur.dp))
    else $error("dp mismatch");

  eight_lit_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) && $past(cur.value) == 4'h8
    |-> seg_q.segment_cathode_n == 7'h00)
    else $error("eight not fully lit");

  seven_pattern_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) && $past(cur.value) == 4'h7
    |-> seg_q.segment_cathode_n == 7'h78)
    else $error("seven pattern wrong");

  zero_pattern_a: assert property (
    @(posedge mclk_in) disable iff (!rstn_in)
    $past(rstn_in) && $past(cur.value) == 4'h0
    |-> seg_q.segment_cathode_n == 7'h40)
    else $error("zero pattern wrong");
endmodule
`default_nettype wire

// ===== sssd_display_model.sv
// partner model: common-anode display that latches what each digit shows
`timescale 1ns/10ps
`default_nettype none
module sssd_disp_model
  import sssd_pkg::*;
(
  // display pins
  input wire logic clk_in,
  input wire logic [3:0] en_n_in,
  input wire sssd_seg_t seg_in,
  // pattern last seen lit on each digit
  output sssd_seg_t shown_out [NUM_DIGITS]
);
  // a digit only glows while its common anode is pulled low
  always @(posedge clk_in) begin
    for (int k = 0; k < NUM_DIGITS; k++) begin
      if (en_n_in[k] == 1'b0) begin
        shown_out[k] <= seg_in;
      end
    end
  end
endmodule
`default_nettype wire

// ===== sssd_tb.sv
// testbench: hex font table, scan order, reset blanking
`timescale 1ns/10ps
`default_nettype none
module seven_segment_scan_driver_tb_top;
  import sssd_pkg::*;
  localparam int TK = 4;
  // active-low font rows, odd rows have the point lit
  localparam logic [7:0] ROWS [16] = '{8'hc0, 8'h79, 8'ha4, 8'h30, 8'h99,
    8'h12, 8'h82, 8'h78, 8'h80, 8'h10, 8'h88, 8'h03, 8'hc6, 8'h21, 8'h86,
    8'h0e};
  logic mclk_in = 1'b0;
  logic rstn_in = 1'b0;
  sssd_digit_t digits_in [NUM_DIGITS] = '{default: '0};
  logic [3:0] en_n;
  sssd_seg_t seg;
  sssd_seg_t shown [NUM_DIGITS];
  int num_errors = 0;
  int n_checks = 0;
  always #2 mclk_in = ~mclk_in;
  sssd_scan_driver #(.DIGIT_TICKS(TK)) dut (.mclk_in(mclk_in),
    .rstn_in(rstn_in), .digits_in(digits_in), .digit_enable_n_out(en_n),
    .segments_out(seg));
  sssd_disp_model disp (.clk_in(mclk_in), .en_n_in(en_n), .seg_in(seg),
    .shown_out(shown));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic check_en(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t enables %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // watchdog: the run needs well under 1000 cycles
  initial begin
    #20000;
    num_errors++;
    results();
  end
  initial begin
    repeat (4) @(negedge mclk_in);
    rstn_in = 1'b1;
    for (int c = 0; c < 16; c++) begin
      @(negedge mclk_in);
      check_en(en_n, ~(4'h1 << (c / TK % 4)));
      if (c == 1) digits_in[0] = 5'h08;
      if (c == 2) check(seg, ROWS[8]);
    end
    for (int r = 0; r < 16; r++) begin
      for (int k = 0; k < 4; k++) begin
        digits_in[k] = 5'((r + k) % 16 + 16 * ((r + k) % 2));
      end
      repeat (4 * TK + 2) @(negedge mclk_in);
      for (int k = 0; k < 4; k++) begin
        check(shown[k], ROWS[(r + k) % 16]);
      end
    end
    // mid-run reset blanks at once; the release then shows 71 on digits 0-1
    rstn_in = 1'b0;
    @(negedge mclk_in);
    check_en(en_n, 4'hf);
    check(seg, 8'hff);
    digits_in[0] = 5'h01;
    digits_in[1] = 5'h07;
    rstn_in = 1'b1;
    @(negedge mclk_in);
    check_en(en_n, 4'he);
    check(seg, 8'hf9);
    repeat (4 * TK + 2) @(negedge mclk_in);
    check(shown[0], 8'hf9);
    check(shown[1], 8'hf8);
    results();
  end
endmodule
`default_nettype wire
